// file: verilog/alu_defs.svh
// register offsets, field positions and reset values of the serial lin uart
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define ALU_OFF_CTL0 8'h00
`define ALU_OFF_TRG 8'h04
`define ALU_OFF_STR0 8'h08
`define ALU_OFF_STR1 8'h0C
`define ALU_OFF_STC 8'h10
`define ALU_OFF_RX 8'h14
`define ALU_OFF_TX 8'h18
`define ALU_OFF_CTL1 8'h20
`define ALU_OFF_CTL2 8'h24
`define ALU_OFF_EMU 8'h34
`define ALU_OFF_IMSK 8'h28
// control_zero fields
`define ALU_C0_PW 7
`define ALU_C0_TXE 6
`define ALU_C0_RXE 5
`define ALU_C0_DCC 0
// control_one_frame_format fields
`define ALU_C1_SLBM 15
`define ALU_C1_BLG_LO 12
`define ALU_C1_STOP2 8
`define ALU_C1_PAR_LO 5
`define ALU_C1_TINV 4
`define ALU_C1_RINV 3
`define ALU_C1_LEN8 2
`define ALU_C1_MSB 1
// trigger bits
`define ALU_TRG_BF 0
// status_one / clear / mask bit positions
`define ALU_ST_PE 0
`define ALU_ST_FE 1
`define ALU_ST_OVE 2
`define ALU_ST_DCE 3
`define ALU_ST_BSF 4
`define ALU_ST_BFE 5
`define ALU_ST_TXD 6
`define ALU_ST_RXD 7
`define ALU_ST_W 8
`define ALU_RST_DIV 16'h0010
`define ALU_BF_MIN_BITS 5'd13
`define ALU_BF_DET_BITS 5'd11
`define ALU_C0_MASK 32'h000000E1
`define ALU_C1_MASK 32'h0000F1FE
`endif

// file: verilog/alu_pkg.sv
// types shared by the serial lin uart
package alu_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} alu_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} alu_rx_e;
  typedef struct packed {
    logic [31:0] ctl0;
    logic [31:0] ctl1;
    logic [15:0] div;
    logic [7:0] imsk;
    logic [7:0] sts;
    logic [7:0] rxd;
    logic rx_full;
    logic [7:0] txd;
    logic tx_full;
    logic emu;
    logic [31:0] rdata;
    logic pw_prev;
    alu_tx_e tx_st;
    logic [15:0] tx_cnt;
    logic [4:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    logic tx_dcc;
    logic tx_stop2;
    alu_rx_e rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [15:0] low_cnt;
    logic [4:0] low_bits;
    logic bf_seen;
    logic rx_prev;
  } alu_state_s;
endpackage

// file: verilog/alu_uart.sv
// serial lin uart with break field, bus monitor and register port
//
// Functional notes
// - separate receive and transmit holding registers
// - seven or eight data bits selectable
// - odd, even, zero or no parity
// - one or two stop bits
// - msb or lsb first both directions
// - optional inversion of tx and rx
// - break field 13 to 20 bits
// - low 11 bits or more flags break
// - break detect also during data reception
// - monitor compares sent bit with readback
// - parity, framing, overrun, consistency, break errors
// - separate tx, rx and status interrupts
// - either reset returns all to initial
// - single peripheral clock for all timing
// - all registers are 32 bit wide
// - unimplemented bits ignored, read zero
// - enable change reinitialises tx and rx
`timescale 1ns/1ps
`include "alu_defs.svh"
module alu_uart #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic deep_stop_wakeup_reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  output logic tx_irq,
  output logic rx_irq,
  output logic status_irq
);
  alu_pkg::alu_state_s q, d;
  logic rst_any;
  logic rx_line, pw, txe, rxe, bit_tick_tx, bit_tick_rx_mid, bit_end_rx;
  logic [1:0] par_mode;
  logic [3:0] nbits;
  logic [7:0] ev, rd_clr;

  // parity of a character, masked to its length
  function automatic logic par_of(input logic [7:0] v, input logic len8);
    par_of = ^(len8 ? v : {1'b0, v[6:0]});
  endfunction

  // parity bit value for the selected mode: 1 odd, 2 even, 3 zero
  function automatic logic par_bit(input logic [1:0] m, input logic p);
    par_bit = (m == 2'd1) ? ~p : (m == 2'd2) ? p : 1'b0;
  endfunction

  // bit reversal of a character within its length, for msb first sending
  function automatic logic [7:0] rev_char(input logic [7:0] v, input logic len8);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    rev_char = len8 ? r : {1'b0, r[7:1]};
  endfunction

  // ----------------------------------------------------------------
  // decode of configuration
  // ----------------------------------------------------------------
  assign rst_any = ~rstn | deep_stop_wakeup_reset;
  assign pw = q.ctl0[`ALU_C0_PW];
  assign txe = pw & q.ctl0[`ALU_C0_TXE];
  assign rxe = pw & q.ctl0[`ALU_C0_RXE];
  assign par_mode = q.ctl1[`ALU_C1_PAR_LO +: 2];
  assign nbits = q.ctl1[`ALU_C1_LEN8] ? 4'd8 : 4'd7;
  assign rx_line = serial_rx_in ^ q.ctl1[`ALU_C1_RINV];
  assign bit_tick_tx = (q.tx_cnt == q.div - 16'd1);
  assign bit_tick_rx_mid = (q.rx_cnt == {1'b0, q.div[15:1]});
  assign bit_end_rx = (q.rx_cnt == q.div - 16'd1);
  // status bits cleared by reading status_one
  assign rd_clr = (rd && addr == `ALU_OFF_STR1) ? 8'hFF : 8'h00;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = 8'h00;
    d.rdata = 32'h0;
    d.pw_prev = pw;
    d.rx_prev = rx_line;
    // register writes; reserved bits are dropped by the masks
    if (wr) begin
      unique case (addr)
        `ALU_OFF_CTL0: d.ctl0 = wdata & `ALU_C0_MASK;
        `ALU_OFF_CTL1: d.ctl1 = wdata & `ALU_C1_MASK;
        `ALU_OFF_CTL2: d.div = (wdata[15:0] < 16'd4) ? 16'd4 : wdata[15:0];
        `ALU_OFF_IMSK: d.imsk = wdata[7:0];
        `ALU_OFF_EMU: d.emu = wdata[7];
        `ALU_OFF_STC: d.sts = q.sts & ~wdata[7:0];
        `ALU_OFF_TX: begin
          if (q.tx_full) ev[`ALU_ST_OVE] = 1'b0;
          d.txd = wdata[7:0];
          d.tx_full = txe;
        end
        `ALU_OFF_TRG: begin
          if (txe && wdata[`ALU_TRG_BF] && q.tx_st == alu_pkg::TX_IDLE) begin
            d.tx_st = alu_pkg::TX_BRK;
            d.tx_cnt = 16'h0;
            d.tx_bit = 5'd0;
            d.tx_line = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // register reads, answered in the next cycle
    if (rd) begin
      unique case (addr)
        `ALU_OFF_CTL0: d.rdata = q.ctl0;
        `ALU_OFF_CTL1: d.rdata = q.ctl1;
        `ALU_OFF_CTL2: d.rdata = {16'h0, q.div};
        `ALU_OFF_IMSK: d.rdata = {24'h0, q.imsk};
        `ALU_OFF_EMU: d.rdata = {24'h0, q.emu, 7'h0};
        `ALU_OFF_STR0: d.rdata = {28'h0, q.tx_st != alu_pkg::TX_IDLE, q.tx_full,
                                   q.rx_st != alu_pkg::RX_IDLE, q.rx_full};
        `ALU_OFF_STR1: d.rdata = {24'h0, q.sts};
        `ALU_OFF_RX: begin
          d.rdata = {24'h0, q.rxd};
          d.rx_full = 1'b0;
        end
        `ALU_OFF_TX: d.rdata = {24'h0, q.txd};
        default: d.rdata = 32'h0;
      endcase
    end

    // transmitter: bit timer from the single clock
    d.tx_cnt = bit_tick_tx ? 16'h0 : q.tx_cnt + 16'd1;
    unique case (q.tx_st)
      alu_pkg::TX_IDLE: begin
        // a break trigger taken in this cycle must keep the line low
        d.tx_line = (d.tx_st != alu_pkg::TX_BRK);
        d.tx_cnt = 16'h0;
        if (q.tx_full && txe && d.tx_st == alu_pkg::TX_IDLE) begin
          d.tx_st = alu_pkg::TX_START;
          d.tx_line = 1'b0;
          d.tx_sh = q.ctl1[`ALU_C1_MSB] ? rev_char(q.txd, q.ctl1[`ALU_C1_LEN8]) : q.txd;
          d.tx_par = par_of(q.txd, q.ctl1[`ALU_C1_LEN8]);
          d.tx_dcc = q.ctl0[`ALU_C0_DCC];
          d.tx_stop2 = q.ctl1[`ALU_C1_STOP2];
          // a write landing in the load cycle stays queued
          d.tx_full = (wr && addr == `ALU_OFF_TX) ? txe : 1'b0;
          d.tx_bit = 5'd0;
        end
      end
      alu_pkg::TX_START, alu_pkg::TX_DATA, alu_pkg::TX_PAR, alu_pkg::TX_STOP: begin
        // bus monitor samples readback in bit middle
        // own bit timer only, so the check works with the receiver off
        if (q.tx_dcc && q.tx_cnt == {1'b0, q.div[15:1]} && rx_line != q.tx_line)
          ev[`ALU_ST_DCE] = 1'b1;
        if (bit_tick_tx) begin
          if (q.tx_st == alu_pkg::TX_START || q.tx_st == alu_pkg::TX_DATA) begin
            if (q.tx_st == alu_pkg::TX_DATA && q.tx_bit == {1'b0, nbits}) begin
              d.tx_st = (par_mode == 2'd0) ? alu_pkg::TX_STOP : alu_pkg::TX_PAR;
              d.tx_line = (par_mode == 2'd0) ? 1'b1 : par_bit(par_mode, q.tx_par);
              d.tx_bit = 5'd0;
            end else begin
              d.tx_st = alu_pkg::TX_DATA;
              d.tx_line = q.tx_sh[0];
              d.tx_sh = {1'b0, q.tx_sh[7:1]};
              d.tx_bit = q.tx_bit + 5'd1;
            end
          end else if (q.tx_st == alu_pkg::TX_PAR) begin
            d.tx_st = alu_pkg::TX_STOP;
            d.tx_line = 1'b1;
            d.tx_bit = 5'd0;
          end else begin
            d.tx_bit = q.tx_bit + 5'd1;
            if (q.tx_bit == (q.tx_stop2 ? 5'd1 : 5'd0)) begin
              d.tx_st = alu_pkg::TX_IDLE;
              ev[`ALU_ST_TXD] = 1'b1;
            end
          end
        end
      end
      alu_pkg::TX_BRK: begin
        // low for 13 + programmed extension bit times
        if (bit_tick_tx) begin
          d.tx_bit = q.tx_bit + 5'd1;
          if (q.tx_bit == `ALU_BF_MIN_BITS - 5'd1 + {2'b0, q.ctl1[`ALU_C1_BLG_LO +: 3]}) begin
            d.tx_st = alu_pkg::TX_STOP;
            d.tx_line = 1'b1;
            d.tx_bit = 5'd0;
            d.tx_stop2 = 1'b0;
          end
        end
      end
      default: d.tx_st = alu_pkg::TX_IDLE;
    endcase

    // receiver
    d.rx_cnt = bit_end_rx ? 16'h0 : q.rx_cnt + 16'd1;
    unique case (q.rx_st)
      alu_pkg::RX_IDLE: begin
        d.rx_cnt = 16'h0;
        if (rxe && q.rx_prev && !rx_line) begin
          d.rx_st = alu_pkg::RX_DATA;
          d.rx_bit = 4'd0;
          d.rx_par = 1'b0;
          d.rx_cnt = 16'd1;
        end
      end
      alu_pkg::RX_DATA: begin
        if (bit_tick_rx_mid && q.rx_bit != 4'd0) begin
          d.rx_sh = q.ctl1[`ALU_C1_MSB] ? {q.rx_sh[6:0], rx_line} : {rx_line, q.rx_sh[7:1]};
          d.rx_par = q.rx_par ^ rx_line;
        end
        if (bit_end_rx) begin
          d.rx_bit = q.rx_bit + 4'd1;
          if (q.rx_bit == nbits) d.rx_st = (par_mode == 2'd0) ? alu_pkg::RX_STOP : alu_pkg::RX_PAR;
        end
      end
      alu_pkg::RX_PAR: begin
        if (bit_tick_rx_mid && rx_line != par_bit(par_mode, q.rx_par)) ev[`ALU_ST_PE] = 1'b1;
        if (bit_end_rx) d.rx_st = alu_pkg::RX_STOP;
      end
      alu_pkg::RX_STOP: begin
        if (bit_tick_rx_mid) begin
          d.rx_st = alu_pkg::RX_IDLE;
          if (!rx_line) ev[`ALU_ST_FE] = 1'b1;
          if (q.rx_full) ev[`ALU_ST_OVE] = 1'b1;
          // a seven bit char drops the stale eighth bit of the shifter
          d.rxd = q.ctl1[`ALU_C1_LEN8] ? q.rx_sh :
                  (q.ctl1[`ALU_C1_MSB] ? {1'b0, q.rx_sh[6:0]} : {1'b0, q.rx_sh[7:1]});
          d.rx_full = 1'b1;
          ev[`ALU_ST_RXD] = 1'b1;
        end
      end
      default: d.rx_st = alu_pkg::RX_IDLE;
    endcase

    // break detector runs independently of the frame receiver
    if (!rxe || rx_line) begin
      if (q.bf_seen && rx_line) begin
        ev[`ALU_ST_BSF] = 1'b1;
        if (q.tx_st == alu_pkg::TX_IDLE && q.rx_st != alu_pkg::RX_IDLE) ev[`ALU_ST_BFE] = 1'b0;
      end
      d.low_cnt = 16'h0;
      d.low_bits = 5'd0;
      d.bf_seen = 1'b0;
    end else begin
      d.low_cnt = (q.low_cnt == q.div - 16'd1) ? 16'h0 : q.low_cnt + 16'd1;
      if (q.low_cnt == q.div - 16'd1 && q.low_bits != 5'd31) d.low_bits = q.low_bits + 5'd1;
      // flag on the edge that completes the eleventh low bit
      if (d.low_bits >= `ALU_BF_DET_BITS && !q.bf_seen) begin
        d.bf_seen = 1'b1;
        d.rx_st = alu_pkg::RX_IDLE; // abort the data frame in progress
        if (q.rx_st != alu_pkg::RX_IDLE && !q.ctl1[`ALU_C1_SLBM]) ev[`ALU_ST_BFE] = 1'b1;
      end
    end

    // sticky status; set wins over clear
    d.sts = (d.sts & ~rd_clr) | ev;

    // enable change reinitialises both units
    if (pw != q.pw_prev || !txe) begin
      d.tx_st = alu_pkg::TX_IDLE;
      d.tx_line = 1'b1;
      if (pw != q.pw_prev) d.tx_full = 1'b0;
    end
    if (pw != q.pw_prev || !rxe) begin
      d.rx_st = alu_pkg::RX_IDLE;
      if (pw != q.pw_prev) d.rx_full = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register, either reset clears everything except div, tx_line and rx_prev
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_any) begin
      q <= '0;
      q.div <= `ALU_RST_DIV;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
      q.tx_st <= alu_pkg::TX_IDLE;
      q.rx_st <= alu_pkg::RX_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = q.rdata;
  assign serial_tx_out = q.tx_line ^ q.ctl1[`ALU_C1_TINV];
  // three request lines, each gated by the mask
  assign tx_irq = q.sts[`ALU_ST_TXD] & q.imsk[`ALU_ST_TXD];
  assign rx_irq = q.sts[`ALU_ST_RXD] & q.imsk[`ALU_ST_RXD];
  assign status_irq = |(q.sts[5:0] & q.imsk[5:0]);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_idle_high;
    @(posedge clk) disable iff (rst_any)
    (q.tx_st == alu_pkg::TX_IDLE && !q.ctl1[`ALU_C1_TINV]) |-> serial_tx_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high");

  property p_start_low;
    @(posedge clk) disable iff (rst_any)
    (q.tx_st == alu_pkg::TX_START) |-> !q.tx_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_read_zero;
    @(posedge clk) disable iff (rst_any)
    (rd && addr == `ALU_OFF_CTL0) |=> (rdata[31:8] == 24'h0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("reserved bits read nonzero");

  property p_rx_full;
    @(posedge clk) disable iff (rst_any)
    (ev[`ALU_ST_RXD]) |=> q.rx_full && q.sts[`ALU_ST_RXD];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("received char not held");

  property p_status_irq;
    @(posedge clk) disable iff (rst_any)
    (ev[`ALU_ST_DCE] && !(wr && addr == `ALU_OFF_IMSK)) |=>
      q.sts[`ALU_ST_DCE] && (status_irq || !q.imsk[`ALU_ST_DCE]);
  endproperty
  a_status_irq: assert property (p_status_irq) else $error("consistency irq missing");

  property p_pw_reinit;
    @(posedge clk) disable iff (rst_any)
    (pw != q.pw_prev) |=> (q.tx_st == alu_pkg::TX_IDLE && q.rx_st == alu_pkg::RX_IDLE);
  endproperty
  a_pw_reinit: assert property (p_pw_reinit) else $error("units not reinitialised");

  property p_brk_low;
    @(posedge clk) disable iff (rst_any)
    (q.tx_st == alu_pkg::TX_BRK) |-> !q.tx_line;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low");

  property p_bf_set;
    @(posedge clk) disable iff (rst_any)
    (q.bf_seen && rx_line && rxe) |=> q.sts[`ALU_ST_BSF];
  endproperty
  a_bf_set: assert property (p_bf_set) else $error("break flag not set");

  property p_stop_high;
    @(posedge clk) disable iff (rst_any)
    (q.tx_st == alu_pkg::TX_STOP) |-> q.tx_line;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_tx_irq;
    @(posedge clk) disable iff (rst_any)
    (ev[`ALU_ST_TXD] && q.imsk[`ALU_ST_TXD] && !(wr && addr == `ALU_OFF_IMSK)) |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

  property p_overrun;
    @(posedge clk) disable iff (rst_any)
    (q.rx_st == alu_pkg::RX_STOP && bit_tick_rx_mid && q.rx_full) |=> q.sts[`ALU_ST_OVE];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rx_off;
    @(posedge clk) disable iff (rst_any)
    (!rxe) |=> (q.rx_st == alu_pkg::RX_IDLE);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver runs while disabled");
endmodule // alu_uart

// file: bench/alu_partner.sv
// remote serial node model facing the uart pins
`timescale 1ns/1ps
module alu_partner (
  input wire logic clk,
  input wire logic [15:0] cfg,
  input wire logic [15:0] div,
  input wire logic line_in,
  output logic line_out,
  input wire logic loop,
  input wire logic corrupt
);
  logic own = 1'b1;
  logic rx_lvl;
  logic bad = 1'b0;
  logic [7:0] got_q[$];
  int run = 0;
  int low_len = 0;
  int cyc = 0;
  int gap = 0;
  // echo mode stands for a shared lin wire; corrupt pulls it low
  assign line_out = loop ? (line_in & ~corrupt) : (own ^ cfg[3]);
  assign rx_lvl = line_in ^ cfg[4];
  function automatic logic par_of(input logic [7:0] d);
    logic p;
    p = cfg[2] ? ^d : ^d[6:0];
    return cfg[6:5] == 2'h1 ? ~p : (cfg[6:5] == 2'h2 ? p : 1'b0);
  endfunction
  function automatic int nbits();
    return cfg[2] ? 8 : 7;
  endfunction
  // length of the last low run, for break fields
  always @(posedge clk) begin
    cyc <= cyc + 1;
    run <= rx_lvl ? 0 : run + 1;
    if (rx_lvl && run != 0) begin
      low_len <= run;
    end
  end
  // frame receiver sampling mid bit; gap is start to start
  initial begin : rx_proc
    logic [7:0] d;
    int t0;
    t0 = 0;
    forever begin
      @(posedge clk);
      if (rx_lvl === 1'b0) begin
        gap = cyc - t0;
        t0 = cyc;
        d = 8'h00;
        repeat (div / 2) @(posedge clk);
        bad = bad | (rx_lvl !== 1'b0);
        for (int i = 0; i < nbits(); i++) begin
          repeat (div) @(posedge clk);
          d[cfg[1] ? nbits() - 1 - i : i] = rx_lvl;
        end
        if (cfg[6:5] != 2'h0) begin
          repeat (div) @(posedge clk);
          bad = bad | (rx_lvl !== par_of(d));
        end
        repeat (cfg[8] ? 2 : 1) begin
          repeat (div) @(posedge clk);
          bad = bad | (rx_lvl !== 1'b1);
        end
        got_q.push_back(d);
      end
    end
  end
  // one frame, with optional wrong parity or low stop bit
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    own <= 1'b0;
    repeat (div) @(posedge clk);
    for (int i = 0; i < nbits(); i++) begin
      own <= cfg[1] ? d[nbits() - 1 - i] : d[i];
      repeat (div) @(posedge clk);
    end
    if (cfg[6:5] != 2'h0) begin
      own <= par_of(d) ^ bad_par;
      repeat (div) @(posedge clk);
    end
    own <= ~bad_stop;
    repeat (div) @(posedge clk);
    own <= 1'b1;
    repeat (div) @(posedge clk);
  endtask
  // plain low period then idle
  task automatic send_low(input int n);
    own <= 1'b0;
    repeat (n * div) @(posedge clk);
    own <= 1'b1;
    repeat (2 * div) @(posedge clk);
  endtask
endmodule // alu_partner

// file: bench/test_alu_uart.sv
// self-checking bench of the serial lin uart against the node model
`timescale 1ns/1ps
`include "alu_defs.svh"
module test_alu_uart;
  localparam int DIV = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic dsr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic rx_line;
  logic tx_line;
  logic tx_irq;
  logic rx_irq;
  logic status_irq;
  logic [15:0] cfg = 16'h0000;
  logic loop = 1'b0;
  logic corrupt = 1'b0;
  logic [31:0] rv;
  int mismatches = 0;
  int n_checks = 0;
  // frame format then character
  logic [23:0] rows [6] = '{24'h0004A5, 24'h00263C, 24'h01445A, 24'h006053, 24'h001E81, 24'h01022C};
  alu_uart i_alu_uart (.clk(clk), .rstn(rstn), .deep_stop_wakeup_reset(dsr), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_rx_in(rx_line), .serial_tx_out(tx_line), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .status_irq(status_irq));
  alu_partner i_alu_partner (.clk(clk), .cfg(cfg), .div(16'(DIV)), .line_in(tx_line), .line_out(rx_line),
    .loop(loop), .corrupt(corrupt));
  always #20 clk = ~clk;
  // ----------------------------------------
  // bus and comparison tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  // strobe dropped one edge before the next may rise
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    rv = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    rd_reg(a);
    check(what, e, rv);
  endtask
  task automatic bits(input int n);
    repeat (n * DIV) @(posedge clk);
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 400 * DIV && i_alu_partner.got_q.size() < n; i++) @(posedge clk);
  endtask
  // format changes may glitch the lines, so both sides are drained
  task automatic settle();
    bits(16);
    rd_reg(`ALU_OFF_RX);
    rd_reg(`ALU_OFF_STR1);
    i_alu_partner.got_q.delete();
    i_alu_partner.bad = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog far beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    int fbits;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("tx idle", 32'h1, tx_line);
    check("irqs", 32'h0, {tx_irq, rx_irq, status_irq});
    rd_chk(`ALU_OFF_CTL2, 32'h10, "ctl2 reset");
    rd_chk(`ALU_OFF_STR1, 32'h0, "status1 reset");
    wr_reg(`ALU_OFF_CTL0, '1);
    rd_chk(`ALU_OFF_CTL0, `ALU_C0_MASK, "ctl0 bits");
    wr_reg(`ALU_OFF_CTL1, '1);
    rd_chk(`ALU_OFF_CTL1, `ALU_C1_MASK, "ctl1 bits");
    wr_reg(`ALU_OFF_EMU, '1);
    rd_chk(`ALU_OFF_EMU, 32'h80, "emu bits");
    wr_reg(8'h3C, '1);
    rd_chk(8'h3C, 32'h0, "unmapped");
    wr_reg(`ALU_OFF_CTL0, 32'h80);
    wr_reg(`ALU_OFF_CTL0, 32'hE0);
    wr_reg(`ALU_OFF_CTL2, DIV);
    // two characters out back to back while one comes in
    foreach (rows[r]) begin
      wr_reg(`ALU_OFF_CTL1, {16'h0, rows[r][23:8]});
      cfg <= rows[r][23:8];
      settle();
      fbits = 2 + (cfg[2] ? 8 : 7) + (cfg[6:5] != 2'h0) + cfg[8];
      n = cfg[2] ? 32'hFF : 32'h7F;
      wr_reg(`ALU_OFF_TX, rows[r][7:0]);
      wr_reg(`ALU_OFF_TX, ~rows[r][7:0]);
      fork
        i_alu_partner.send(rows[r][7:0], 1'b0, 1'b0);
        wait_rx(2);
      join
      check("tx first", rows[r][7:0] & n, i_alu_partner.got_q[0]);
      check("tx second", ~rows[r][7:0] & n, i_alu_partner.got_q[1]);
      // one idle cycle separates queued frames
      check("frame length", fbits * DIV + 1, i_alu_partner.gap);
      check("tx frame", 32'h0, i_alu_partner.bad);
      bits(2);
      rd_chk(`ALU_OFF_RX, rows[r][7:0] & n, "rx data");
    end
    // receive errors and the status interrupt
    wr_reg(`ALU_OFF_CTL1, 32'h8044);
    cfg <= 16'h8044;
    wr_reg(`ALU_OFF_IMSK, 32'hFF);
    settle();
    i_alu_partner.send(8'h11, 1'b1, 1'b0);
    check("status irq", 32'h1, status_irq);
    rd_reg(`ALU_OFF_STR1);
    check("parity err", 32'h1, rv[`ALU_ST_PE]);
    bits(1);
    check("status irq low", 32'h0, status_irq);
    rd_reg(`ALU_OFF_RX);
    i_alu_partner.send(8'h22, 1'b0, 1'b1);
    rd_reg(`ALU_OFF_STR1);
    check("framing err", 32'h1, rv[`ALU_ST_FE]);
    rd_reg(`ALU_OFF_RX);
    i_alu_partner.send(8'h33, 1'b0, 1'b0);
    check("rx irq", 32'h1, rx_irq);
    i_alu_partner.send(8'h44, 1'b0, 1'b0);
    check("overrun irq", 32'h1, status_irq);
    wr_reg(`ALU_OFF_STC, 32'h4);
    rd_reg(`ALU_OFF_STR1);
    check("overrun cleared", 32'h1, rv[`ALU_ST_RXD:`ALU_ST_OVE] == 6'h20);
    // break detection boundary, frames still arriving
    rd_reg(`ALU_OFF_RX);
    i_alu_partner.send_low(10);
    rd_reg(`ALU_OFF_STR1);
    check("no break at 10", 32'h0, rv[`ALU_ST_BSF]);
    rd_reg(`ALU_OFF_RX);
    i_alu_partner.send_low(11);
    rd_reg(`ALU_OFF_STR1);
    check("break at 11", 32'h1, rv[`ALU_ST_BSF]);
    // sent break at both ends of its range
    for (int b = 0; b < 8; b += 7) begin
      wr_reg(`ALU_OFF_CTL1, 32'h8044 | (b << 12));
      wr_reg(`ALU_OFF_TRG, 32'h1);
      bits(24);
      check("break length", (13 + b) * DIV, i_alu_partner.low_len);
    end
    // bus monitor on an echoed wire, clean then corrupted with irq masked
    wr_reg(`ALU_OFF_CTL0, 32'hE1);
    loop <= 1'b1;
    settle();
    wr_reg(`ALU_OFF_TX, 32'h0F);
    wait_rx(1);
    bits(2);
    check("tx irq", 32'h1, tx_irq);
    rd_reg(`ALU_OFF_STR1);
    check("no consistency err", 32'h0, rv[`ALU_ST_DCE]);
    wr_reg(`ALU_OFF_IMSK, 32'h0);
    i_alu_partner.got_q.delete();
    wr_reg(`ALU_OFF_TX, 32'hFF);
    bits(3);
    corrupt <= 1'b1;
    bits(2);
    corrupt <= 1'b0;
    wait_rx(1);
    bits(2);
    check("masked irq", 32'h0, status_irq);
    rd_reg(`ALU_OFF_STR1);
    check("consistency err", 32'h1, rv[`ALU_ST_DCE]);
    // enable dropped in mid frame
    loop <= 1'b0;
    wr_reg(`ALU_OFF_TX, 32'h00);
    bits(3);
    check("tx mid frame", 32'h0, tx_line);
    wr_reg(`ALU_OFF_CTL0, 32'h60);
    @(posedge clk);
    check("tx flushed", 32'h1, tx_line);
    rd_reg(`ALU_OFF_STR0);
    check("tx unit idle", 32'h0, rv[3:2]);
    // wake-up reset alone
    dsr <= 1'b1;
    @(posedge clk);
    dsr <= 1'b0;
    @(posedge clk);
    rd_chk(`ALU_OFF_CTL0, 32'h0, "ctl0 after wakeup");
    rd_chk(`ALU_OFF_CTL2, 32'h10, "ctl2 after wakeup");
    final_report();
  end
endmodule // test_alu_uart
